// File: hdl/fcmp_less_pkg.sv
// Purpose: shared constants and carriers for the float less-compare unit
// Assumes: one clock domain, registers on a plain strobe port
// Notes: flag vector layout is shared by the destination and the status word
package fcmp_less_pkg;

   // operation codes handled by this unit
   localparam logic [7:0] OP_LESS_BOOL = 8'h90;   // boolean less-than, code 144
   localparam logic [7:0] OP_LESS_FLAGS = 8'h91;  // flags-only less-than, code 145
   localparam logic [7:0] OP_LEQ_BOOL = 8'h92;    // boolean less-or-equal, code 146
   localparam logic [7:0] OP_LEQ_FLAGS = 8'h93;   // flags-only less-or-equal, code 147

   // the only issue slot that feeds this unit
   localparam logic [2:0] COMPARE_SLOT = 3'h3;
   // cycles from issue to writeback
   localparam int COMPARE_LATENCY = 1;

   // exception flag vector layout
   localparam int FLAG_WIDTH = 7;
   localparam int DIVIDE_BY_ZERO_FLAG = 0;
   localparam int INEXACT_FLAG = 1;
   localparam int UNDERFLOW_FLAG = 2;
   localparam int OVERFLOW_FLAG = 3;
   localparam int INVALID_OPERATION_FLAG = 4;
   localparam int INPUT_FLUSHED_FLAG = 5;
   localparam int OUTPUT_FLUSHED_FLAG = 6;

   // single-precision field layout
   localparam int EXP_MSB = 30;
   localparam int EXP_LSB = 23;
   localparam int MANT_MSB = 22;
   localparam int SIGN_BIT = 31;
   localparam logic [7:0] EXP_ALL_ONES = 8'hff;
   localparam logic [7:0] EXP_ZERO = 8'h00;

   // register map, byte addresses
   localparam logic [7:0] REG_STATUS_WORD = 8'h00;  // processor_status_word flags
   localparam logic [7:0] REG_EVENT = 8'h04;        // sticky events, write one to clear
   localparam logic [7:0] REG_EVENT_MASK = 8'h08;   // interrupt enables
   localparam logic [6:0] STATUS_WORD_RESET = 7'h00;
   localparam logic [2:0] EVENT_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // event bit positions
   localparam int EVENT_WIDTH = 3;
   localparam int EV_INVALID = 0;   // boolean compare raised invalid
   localparam int EV_FLUSHED = 1;   // boolean compare raised input flushed
   localparam int EV_REFUSED = 2;   // issue to wrong slot or unknown code

   // one issued operation
   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [2:0] slot;
      logic guard_present;
      logic guard_lsb;
      logic [6:0] dest_idx;
      logic [31:0] source_one;
      logic [31:0] source_two;
   } issue_t;

   // one destination writeback
   typedef struct packed {
      logic write_en;
      logic [6:0] dest_idx;
      logic [31:0] data;
   } result_t;

endpackage

// File: hdl/float_compare_less_flags_unit.sv
// Purpose: single-precision less-than / less-or-equal compare unit
// Assumes: issue logic presents one operation per cycle with operands ready
// Notes: latency one; destination and status word change on the same edge
//
// Operation
// - flags-only less-or-equal, code 147, returns flags
// - flags less-or-equal is swapped greater-or-equal
// - flags-only forms never touch status word
// - flags forms flush denormals, set bit 5
// - flag vector bits 0..6, upper bits zero
// - boolean less-than writes one or zero
// - boolean less-than is swapped greater-than
// - operands single-precision, integer result
// - boolean form flushes denormals, sets status flag
// - status flags sticky, cleared only by write
// - status flags update with destination write
// - simultaneous updates OR with previous value
// - boolean guard gates destination and status flags
// - flags-form guard gates destination only
// - one-cycle latency, slot three only
// - boolean less-than 144, flags less-than 145
// - flags less-than is swapped greater-than flags
`timescale 1ns/100ps
module float_compare_less_flags_unit
   import fcmp_less_pkg::*;
(
   input wire logic ref_clk_i,                         // core clock, 10 MHz
   input wire logic reset_n_i,                         // async reset, active low
   input wire issue_t issue_i,                         // operation from issue logic
   input wire logic [FLAG_WIDTH-1:0] other_flags_i,    // same-cycle flags of other units
   input wire logic [7:0] reg_addr_i,                  // register byte address
   input wire logic [31:0] reg_wdata_i,                // register write data
   input wire logic reg_write_i,                       // one-cycle write strobe
   input wire logic reg_read_i,                        // one-cycle read strobe
   output result_t result_o,                           // destination writeback
   output logic [FLAG_WIDTH-1:0] status_flags_o,       // processor_status_word flags
   output logic [31:0] reg_rdata_o,                    // read data, cycle after strobe
   output logic irq_o                                  // level interrupt
);

   // ---------------------------------------------------------------
   // operand helpers
   // ---------------------------------------------------------------

   // exponent all ones with a nonzero fraction
   function automatic logic is_nan(input logic [31:0] v);
      is_nan = (v[EXP_MSB:EXP_LSB] == EXP_ALL_ONES) && (v[MANT_MSB:0] != 23'h000000);
   endfunction

   // exponent zero with a nonzero fraction
   function automatic logic is_denorm(input logic [31:0] v);
      is_denorm = (v[EXP_MSB:EXP_LSB] == EXP_ZERO) && (v[MANT_MSB:0] != 23'h000000);
   endfunction

   // denormals become zero of the same sign
   function automatic logic [31:0] flush(input logic [31:0] v);
      flush = is_denorm(v) ? {v[SIGN_BIT], 31'h00000000} : v;
   endfunction

   // both magnitudes zero, so +0 and -0 compare equal
   function automatic logic both_zero(input logic [31:0] a, input logic [31:0] b);
      both_zero = (a[EXP_MSB:0] == 31'h00000000) && (b[EXP_MSB:0] == 31'h00000000);
   endfunction

   // ordered greater-than on flushed non-NaN values
   function automatic logic ordered_gt(input logic [31:0] a, input logic [31:0] b);
      logic res;
      res = 1'b0;
      if (both_zero(a, b)) begin
         res = 1'b0;
      end else if (a[SIGN_BIT] != b[SIGN_BIT]) begin
         // differing signs: the positive one is larger
         res = ~a[SIGN_BIT];
      end else if (!a[SIGN_BIT]) begin
         // both positive: magnitude order
         res = a[EXP_MSB:0] > b[EXP_MSB:0];
      end else begin
         // both negative: reversed magnitude order
         res = a[EXP_MSB:0] < b[EXP_MSB:0];
      end
      ordered_gt = res;
   endfunction

   // ordered greater-or-equal on flushed non-NaN values
   function automatic logic ordered_ge(input logic [31:0] a, input logic [31:0] b);
      ordered_ge = ordered_gt(a, b) || (a == b) || both_zero(a, b);
   endfunction

   // ---------------------------------------------------------------
   // decode of the issued operation
   // ---------------------------------------------------------------

   logic code_known;       // opcode belongs to this unit
   logic slot_ok;          // issued in the compare slot
   logic accept;           // operation taken by this unit, guard not yet applied
   logic refused;          // valid issue that this unit rejects
   logic is_bool;          // boolean form, touches the status word
   logic is_leq;           // less-or-equal rather than strict
   logic guard_true;       // guard absent or guard lsb set

   assign code_known = (issue_i.opcode == OP_LESS_BOOL) || (issue_i.opcode == OP_LESS_FLAGS)
                    || (issue_i.opcode == OP_LEQ_BOOL) || (issue_i.opcode == OP_LEQ_FLAGS);
   assign slot_ok = (issue_i.slot == COMPARE_SLOT);
   assign accept = issue_i.valid && code_known && slot_ok;
   assign refused = issue_i.valid && !(code_known && slot_ok);
   assign is_bool = (issue_i.opcode == OP_LESS_BOOL) || (issue_i.opcode == OP_LEQ_BOOL);
   assign is_leq = (issue_i.opcode == OP_LEQ_BOOL) || (issue_i.opcode == OP_LEQ_FLAGS);
   // a missing guard means always execute
   assign guard_true = !issue_i.guard_present || issue_i.guard_lsb;

   // ---------------------------------------------------------------
   // compare datapath, all combinational within the issue cycle
   // ---------------------------------------------------------------

   logic [31:0] op_one;                 // flushed source_one
   logic [31:0] op_two;                 // flushed source_two
   logic any_nan;                       // unordered pair
   logic any_denorm;                    // an input was flushed
   logic cmp_true;                      // relation holds
   logic [FLAG_WIDTH-1:0] cmp_flags;    // flags this compare would raise
   logic [31:0] bool_word;              // integer 0 or 1
   logic [31:0] flag_word;              // integer flag vector

   // same flush for the boolean form
   assign op_one = flush(issue_i.source_one);
   assign op_two = flush(issue_i.source_two);
   assign any_nan = is_nan(issue_i.source_one) || is_nan(issue_i.source_two);
   assign any_denorm = is_denorm(issue_i.source_one) || is_denorm(issue_i.source_two);

   // the relation is evaluated with the operands exchanged, so both
   // less forms share the greater logic; a NaN makes every relation false
   always_comb begin
      cmp_true = 1'b0;
      if (any_nan) begin
         cmp_true = 1'b0;
      end else if (is_leq) begin
         cmp_true = ordered_ge(op_two, op_one);
      end else begin
         cmp_true = ordered_gt(op_two, op_one);
      end
   end

   // a compare can only raise invalid and input-flushed; the others stay
   // zero, which keeps the vector layout fixed for all compare forms
   always_comb begin
      cmp_flags = '0;
      cmp_flags[INVALID_OPERATION_FLAG] = any_nan;
      cmp_flags[INPUT_FLUSHED_FLAG] = any_denorm;
      cmp_flags[DIVIDE_BY_ZERO_FLAG] = 1'b0;
      cmp_flags[INEXACT_FLAG] = 1'b0;
      cmp_flags[UNDERFLOW_FLAG] = 1'b0;
      cmp_flags[OVERFLOW_FLAG] = 1'b0;
      cmp_flags[OUTPUT_FLUSHED_FLAG] = 1'b0;
   end

   assign bool_word = {31'h00000000, cmp_true};
   assign flag_word = {25'h0000000, cmp_flags};

   // ---------------------------------------------------------------
   // destination writeback, one cycle after issue
   // ---------------------------------------------------------------

   // the write enable falls back to zero when nothing is issued, so the
   // destination is only ever written by a guarded, accepted operation
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         result_o <= '0;
      end else begin
         result_o.write_en <= accept && guard_true;
         result_o.dest_idx <= issue_i.dest_idx;
         result_o.data <= is_bool ? bool_word : flag_word;
      end
   end

   // ---------------------------------------------------------------
   // status word exception flags
   // ---------------------------------------------------------------

   logic bool_commit;                        // boolean op commits this cycle
   logic [FLAG_WIDTH-1:0] own_update;        // this unit's contribution
   logic [FLAG_WIDTH-1:0] next_status;       // next status flags
   logic status_write;                       // explicit status-word write

   assign bool_commit = accept && is_bool && guard_true;
   assign own_update = bool_commit ? cmp_flags : '0;
   assign status_write = reg_write_i && (reg_addr_i == REG_STATUS_WORD);

   // an explicit write replaces the stored flags, but raises arriving in
   // the same cycle are still ORed on top so no exception is lost
   always_comb begin
      if (status_write) begin
         next_status = reg_wdata_i[FLAG_WIDTH-1:0] | own_update | other_flags_i;
      end else begin
         next_status = status_flags_o | own_update | other_flags_i;
      end
   end

   // registered on the same edge as result_o, so the flags appear together
   // with the destination write
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_flags_o <= STATUS_WORD_RESET;
      end else begin
         status_flags_o <= next_status;
      end
   end

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------

   logic [EVENT_WIDTH-1:0] event_bits;    // sticky event status
   logic [EVENT_WIDTH-1:0] event_mask;    // interrupt enables
   logic [EVENT_WIDTH-1:0] event_set;     // events raised this cycle
   logic [EVENT_WIDTH-1:0] event_clear;   // write-one-to-clear pattern
   logic [EVENT_WIDTH-1:0] next_events;   // next sticky event status

   always_comb begin
      event_set = '0;
      event_set[EV_INVALID] = own_update[INVALID_OPERATION_FLAG];
      event_set[EV_FLUSHED] = own_update[INPUT_FLUSHED_FLAG];
      event_set[EV_REFUSED] = refused;
   end

   assign event_clear = (reg_write_i && (reg_addr_i == REG_EVENT))
                      ? reg_wdata_i[EVENT_WIDTH-1:0] : '0;
   // a new event beats a clear in the same cycle
   assign next_events = (event_bits & ~event_clear) | event_set;

   // sticky event register
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         event_bits <= EVENT_RESET;
      end else begin
         event_bits <= next_events;
      end
   end

   // mask register, plain read/write
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         event_mask <= MASK_RESET;
      end else if (reg_write_i && (reg_addr_i == REG_EVENT_MASK)) begin
         event_mask <= reg_wdata_i[EVENT_WIDTH-1:0];
      end
   end

   // interrupt is built from the next bits and next mask, so it changes on the same
   // edge as the stored bits, and the output still comes straight from a flip-flop
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(next_events & (reg_write_i && (reg_addr_i == REG_EVENT_MASK)
                  ? reg_wdata_i[EVENT_WIDTH-1:0] : event_mask));
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------

   // read data stand for exactly one cycle, zero otherwise and for any
   // unmapped address; values are those before a same-cycle write
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_read_i) begin
         case (reg_addr_i)
            REG_STATUS_WORD: reg_rdata_o <= {25'h0000000, status_flags_o};
            REG_EVENT: reg_rdata_o <= {29'h00000000, event_bits};
            REG_EVENT_MASK: reg_rdata_o <= {29'h00000000, event_mask};
            default: reg_rdata_o <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

endmodule

// File: tb/fcmp_less_chk.sv
// Purpose: port-level assertions for the float less-compare unit
// Assumes: one clock domain, async active-low reset
// Notes: sees only the unit's ports; bound in below
`timescale 1ns/100ps
module fcmp_less_chk
   import fcmp_less_pkg::*;
(
   input wire logic ref_clk_i,                      // core clock
   input wire logic reset_n_i,                      // reset, active low
   input wire issue_t issue_i,                      // issued op
   input wire logic [FLAG_WIDTH-1:0] other_flags_i, // other units' flags
   input wire logic [7:0] reg_addr_i,               // register address
   input wire logic [31:0] reg_wdata_i,             // register write data
   input wire logic reg_write_i,                    // write strobe
   input wire logic reg_read_i,                     // read strobe
   input wire result_t result_o,                    // writeback
   input wire logic [FLAG_WIDTH-1:0] status_flags_o, // status word flags
   input wire logic [31:0] reg_rdata_o,             // read data
   input wire logic irq_o                           // interrupt
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // nan test on the raw operand, before any flush
   function automatic logic nan(input logic [31:0] x);
      return x[EXP_MSB:EXP_LSB] == EXP_ALL_ONES && x[MANT_MSB:0] != 23'h0;
   endfunction
   // op that must reach writeback: known code, right slot, guard true
   wire exec = issue_i.valid && issue_i.slot == COMPARE_SLOT
      && issue_i.opcode >= OP_LESS_BOOL && issue_i.opcode <= OP_LEQ_FLAGS
      && (!issue_i.guard_present || issue_i.guard_lsb);
   wire is_bool = issue_i.opcode == OP_LESS_BOOL || issue_i.opcode == OP_LEQ_BOOL;
   wire st_wr = reg_write_i && reg_addr_i == REG_STATUS_WORD; // explicit clear path
   wire any_nan = nan(issue_i.source_one) || nan(issue_i.source_two);
   property p_wen; exec |=> result_o.write_en; endproperty
   a_wen: assert property (p_wen) else $error("no writeback one cycle after issue");
   property p_nowen; !exec |=> !result_o.write_en; endproperty
   a_nowen: assert property (p_nowen) else $error("writeback without executed op");
   property p_dest; exec |=> result_o.dest_idx == $past(issue_i.dest_idx); endproperty
   a_dest: assert property (p_dest) else $error("destination index changed");
   property p_bool; exec && is_bool |=> result_o.data[31:1] == 31'h0; endproperty
   a_bool: assert property (p_bool) else $error("boolean result not zero or one");
   property p_vec; exec && !is_bool |=> result_o.data[31:7] == 25'h0; endproperty
   a_vec: assert property (p_vec) else $error("flag vector upper bits set");
   property p_keep;
      exec && !is_bool && !st_wr && other_flags_i == 7'h00 |=> $stable(status_flags_o);
   endproperty
   a_keep: assert property (p_keep) else $error("flags form changed status word");
   property p_sticky;
      !st_wr |=> (status_flags_o & $past(status_flags_o)) == $past(status_flags_o);
   endproperty
   a_sticky: assert property (p_sticky) else $error("status flag fell without write");
   property p_other;
      1'b1 |=> (status_flags_o & $past(other_flags_i)) == $past(other_flags_i);
   endproperty
   a_other: assert property (p_other) else $error("other unit flag not merged");
   property p_nan;
      exec && is_bool && any_nan |=>
         result_o.data == 32'h0 && status_flags_o[INVALID_OPERATION_FLAG];
   endproperty
   a_nan: assert property (p_nan) else $error("nan compare not unordered");
   property p_rd; !reg_read_i |=> reg_rdata_o == 32'h0; endproperty
   a_rd: assert property (p_rd) else $error("read data outside read cycle");
endmodule

bind float_compare_less_flags_unit fcmp_less_chk fcmp_less_chk_i (.ref_clk_i, .reset_n_i,
   .issue_i, .other_flags_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
   .result_o, .status_flags_o, .reg_rdata_o, .irq_o);

// File: tb/core_writeback_model.sv
// Purpose: destination register file on the core's writeback side
// Assumes: at most one writeback a cycle from the compare unit
// Notes: behavioural; a register keeps its value when nothing writes it
`timescale 1ns/100ps
module core_writeback_model
   import fcmp_less_pkg::*;
(
   input wire logic ref_clk_i,  // core clock
   input wire logic reset_n_i,  // reset, active low
   input wire result_t result_i // writeback from the unit
);
   logic [31:0] dest_reg [128]; // destination registers
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 128; i++) begin
            dest_reg[i] <= 32'h0;
         end
      end else if (result_i.write_en) begin
         dest_reg[result_i.dest_idx] <= result_i.data;
      end
   end
endmodule

// File: tb/float_compare_less_flags_unit_tb.sv
// Purpose: self-checking bench for the float less-compare unit
// Assumes: one op per issue with an idle cycle between, bus strobes one cycle
// Notes: operands are fixed values, every expectation worked out by hand
`timescale 1ns/100ps
module float_compare_less_flags_unit_tb;
   import fcmp_less_pkg::*;
   localparam logic [31:0] F0 = 32'h0, F1 = 32'h3f800000, F3 = 32'h40400000;
   localparam logic [31:0] PINF = 32'h7f800000, NINF = 32'hff800000;
   localparam logic [31:0] QNAN = 32'h7fffffff, DEN = 32'h00400000;
   logic ref_clk_i = 1'b0; // core clock
   logic reset_n_i = 1'b0; // reset, active low
   issue_t issue_i = '0; // issued op
   logic [FLAG_WIDTH-1:0] other_flags_i = '0; // other units' flags
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_write_i = 1'b0;
   logic reg_read_i = 1'b0;
   result_t result_o;
   logic [FLAG_WIDTH-1:0] status_flags_o;
   logic [31:0] reg_rdata_o;
   logic irq_o;
   int error_cnt = 0;
   int total_checks = 0;
   // 10 MHz core clock
   always #50 ref_clk_i = ~ref_clk_i;
   float_compare_less_flags_unit float_compare_less_flags_unit_i (.ref_clk_i, .reset_n_i,
      .issue_i, .other_flags_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
      .result_o, .status_flags_o, .reg_rdata_o, .irq_o);
   core_writeback_model core_writeback_model_i (.ref_clk_i, .reset_n_i, .result_i(result_o));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one issue; write enable and data judged just after the writeback edge
   task automatic op(input logic [7:0] code, input logic [2:0] slot, input logic [1:0] g,
         input logic [31:0] a, input logic [31:0] b, input logic [32:0] exp);
      @(posedge ref_clk_i);
      issue_i <= '{1'b1, code, slot, g[1], g[0], 7'h05, a, b};
      @(posedge ref_clk_i);
      issue_i <= '0;
      #1;
      chk({31'h0, result_o.write_en}, {31'h0, exp[32]});
      if (exp[32]) begin
         chk(result_o.data, exp[31:0]);
      end
   endtask
   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      @(posedge ref_clk_i);
      reg_write_i <= 1'b1;
      reg_addr_i <= addr;
      reg_wdata_i <= data;
      @(posedge ref_clk_i);
      reg_write_i <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
      @(posedge ref_clk_i);
      reg_read_i <= 1'b1;
      reg_addr_i <= addr;
      @(posedge ref_clk_i);
      reg_read_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask
   task automatic t_regs();
      rd(REG_STATUS_WORD, 32'h0);
      rd(REG_EVENT, 32'h0);
      rd(REG_EVENT_MASK, 32'h0);
      wr(8'h0c, 32'hffffffff);
      rd(8'h0c, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      $display("test regs done");
   endtask
   // ordered, equal, infinite and denormal pairs, both boolean codes
   task automatic t_bool();
      logic [31:0] a [8] = '{F3, F3, F1, F3, PINF, NINF, PINF, F1};
      logic [31:0] b [8] = '{F0, F3, F3, F1, NINF, PINF, PINF, DEN};
      logic [7:0] lt = 8'h24;
      logic [7:0] le = 8'h66;
      wr(REG_STATUS_WORD, 32'h0);
      for (int i = 0; i < 8; i++) begin
         op(OP_LESS_BOOL, COMPARE_SLOT, 2'b00, a[i], b[i], {1'b1, 31'h0, lt[i]});
         op(OP_LEQ_BOOL, COMPARE_SLOT, 2'b00, a[i], b[i], {1'b1, 31'h0, le[i]});
      end
      chk({25'h0, status_flags_o}, 32'h20);
      rd(REG_EVENT, 32'h2);
      $display("test bool done");
   endtask
   task automatic t_flags();
      logic [31:0] a [6] = '{F3, F1, F3, F1, DEN, PINF};
      logic [31:0] b [6] = '{F0, F3, QNAN, DEN, QNAN, PINF};
      logic [31:0] f [6] = '{32'h0, 32'h0, 32'h10, 32'h20, 32'h30, 32'h0};
      wr(REG_STATUS_WORD, 32'h0);
      for (int i = 0; i < 6; i++) begin
         op(OP_LESS_FLAGS, COMPARE_SLOT, 2'b00, a[i], b[i], {1'b1, f[i]});
         op(OP_LEQ_FLAGS, COMPARE_SLOT, 2'b00, a[i], b[i], {1'b1, f[i]});
      end
      chk({25'h0, status_flags_o}, 32'h0);
      $display("test flags done");
   endtask
   task automatic t_guard();
      wr(REG_STATUS_WORD, 32'h0);
      op(OP_LESS_FLAGS, COMPARE_SLOT, 2'b11, F1, DEN, {1'b1, 32'h20});
      op(OP_LESS_FLAGS, COMPARE_SLOT, 2'b10, F3, QNAN, {1'b0, 32'h0});
      chk(core_writeback_model_i.dest_reg[5], 32'h20);
      op(OP_LESS_BOOL, COMPARE_SLOT, 2'b10, F3, QNAN, {1'b0, 32'h0});
      chk({25'h0, status_flags_o}, 32'h0);
      op(OP_LESS_BOOL, COMPARE_SLOT, 2'b11, F1, F3, {1'b1, 32'h1});
      $display("test guard done");
   endtask
   task automatic t_status();
      wr(REG_STATUS_WORD, 32'h0);
      op(OP_LESS_BOOL, COMPARE_SLOT, 2'b00, F3, QNAN, {1'b1, 32'h0});
      chk({25'h0, status_flags_o}, 32'h10);
      @(posedge ref_clk_i);
      other_flags_i <= 7'h41;
      @(posedge ref_clk_i);
      other_flags_i <= 7'h00;
      #1;
      chk({25'h0, status_flags_o}, 32'h51);
      op(OP_LESS_BOOL, COMPARE_SLOT, 2'b00, F1, F3, {1'b1, 32'h1});
      rd(REG_STATUS_WORD, 32'h51);
      wr(REG_STATUS_WORD, 32'h0);
      chk({25'h0, status_flags_o}, 32'h0);
      $display("test status done");
   endtask
   // event raise, mask, write-one clear, refused issue
   task automatic t_irq();
      wr(REG_EVENT, 32'h7);
      op(OP_LESS_BOOL, COMPARE_SLOT, 2'b00, F3, QNAN, {1'b1, 32'h0});
      rd(REG_EVENT, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      wr(REG_EVENT_MASK, 32'h5);
      chk({31'h0, irq_o}, 32'h1);
      rd(REG_EVENT_MASK, 32'h5);
      wr(REG_EVENT, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      op(OP_LESS_BOOL, 3'h2, 2'b00, F1, F3, {1'b0, 32'h0});
      op(8'h94, COMPARE_SLOT, 2'b00, F1, F3, {1'b0, 32'h0});
      rd(REG_EVENT, 32'h4);
      chk({31'h0, irq_o}, 32'h1);
      $display("test irq done");
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      t_regs();
      t_bool();
      t_flags();
      t_guard();
      t_status();
      t_irq();
      give_verdict();
   end
   // hang guard, far beyond the scripted run
   initial begin
      #2000000;
      error_cnt++;
      give_verdict();
   end
endmodule
